// file: rtl/ntd_pkg.sv
// Package with the register map, field layout and timing figures of the timebase divider.
`default_nettype none
package ntd_pkg;
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned DIV_W        = 11;
    localparam logic [7:0]  OFS_DIV_HIGH = 8'h00;
    localparam logic [7:0]  OFS_DIV_LOW  = 8'h01;
    localparam logic [7:0]  OFS_CONFIG   = 8'h02;
    localparam int unsigned LOCK_BIT     = 7;
    localparam int unsigned DIV_HI_MSB   = 2;
    localparam int unsigned REF_SEL_BIT  = 0;
    localparam logic        REF_SEL_RST  = 1'b0;
    localparam int unsigned TIMEBASE_NS  = 35000;
    localparam int unsigned MIN_OP_MS    = 10;
    localparam int unsigned MIN_OP_TICKS = (MIN_OP_MS * 1000000 + TIMEBASE_NS - 1) / TIMEBASE_NS;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ntd_req_t;

    typedef struct packed {
        logic osc_ref;
        logic bus_ref;
    } ntd_ref_t;
endpackage
`default_nettype wire

// file: rtl/ntd_divider.sv
// Timebase divider with its divisor, lock and reference-select registers.
//
// Our own choices: the strobed register port and the address map.
`default_nettype none
// How it works
// - The reference is either the oscillator output clock or the system bus clock.
// - One reference-select bit in the configuration register picks the reference.
// - The selected reference is divided by the divisor to give the nominal 35 us tick.
// - Reset copies the two shadow bytes into the divisor registers; software may also write them.
// - The divisor is 11 bits, split over a high and a low register.
// - Software writes to the divisor take effect only while the lock-disable bit is set.
// - While the proposed map is not active, divisor writes have no effect.
// - Lock-disable 1 unlocks, 0 locks the divisor registers and the bit itself.
// - The divisor always reads back and is writable only with latch clear and lock disabled.
// - New shadow contents reach the divisor registers only at the next reset.
module ntd_divider (
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire ntd_pkg::ntd_req_t bus_req,
    output logic [7:0]             rd_data,
    input  wire ntd_pkg::ntd_ref_t ref_pulse,
    input  wire logic [7:0]        divisor_high_shadow,
    input  wire logic [7:0]        divisor_low_shadow,
    input  wire logic              memory_latch_bit,
    input  wire logic              map_active,
    output logic                   timebase_tick,
    output logic                   divider_ref_select
);
    logic [ntd_pkg::DIV_W-1:0] div_r;
    logic                      lock_dis_r;
    logic                      ref_sel_r;
    logic [ntd_pkg::DIV_W-1:0] cnt_r;
    logic [ntd_pkg::DIV_W-1:0] cnt_nxt;
    logic                      tick_r;
    logic                      tick_nxt;
    logic [7:0]                rd_r;
    logic [7:0]                rd_nxt;
    logic                      ref_edge;
    logic                      div_wr_ok;
    logic                      wr_hi;
    logic                      wr_lo;

    // The selected source arrives as one strobe per reference period.
    assign ref_edge  = ref_sel_r ? ref_pulse.bus_ref : ref_pulse.osc_ref;
    assign div_wr_ok = map_active && lock_dis_r && !memory_latch_bit;
    assign wr_hi     = bus_req.wr && bus_req.addr == ntd_pkg::OFS_DIV_HIGH;
    assign wr_lo     = bus_req.wr && bus_req.addr == ntd_pkg::OFS_DIV_LOW;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            div_r <= {divisor_high_shadow[ntd_pkg::DIV_HI_MSB:0], divisor_low_shadow};
        end else begin
            if (wr_hi && div_wr_ok) begin
                div_r[ntd_pkg::DIV_W-1:8] <= bus_req.wdata[ntd_pkg::DIV_HI_MSB:0];
            end
            if (wr_lo && div_wr_ok) begin
                div_r[7:0] <= bus_req.wdata;
            end
        end
    end

    // The lock-disable bit is cleared by software or by a reset with shadow bit 7 clear; once clear, only a reset can set it again.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            lock_dis_r <= divisor_high_shadow[ntd_pkg::LOCK_BIT];
        end else if (wr_hi && map_active && lock_dis_r) begin
            lock_dis_r <= bus_req.wdata[ntd_pkg::LOCK_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ref_sel_r <= ntd_pkg::REF_SEL_RST;
        end else if (bus_req.wr && bus_req.addr == ntd_pkg::OFS_CONFIG) begin
            ref_sel_r <= bus_req.wdata[ntd_pkg::REF_SEL_BIT];
        end
    end

    always_comb begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (div_r == '0) begin
            cnt_nxt = '0;
        end else if (ref_edge) begin
            // A divisor cut below the running count wraps at the next strobe,
            // so the timer never waits for a full counter overflow.
            if (cnt_r >= div_r - 11'h001) begin
                cnt_nxt  = '0;
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 11'h001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    // Read data stand for one cycle only and fall back to zero when no read is pending.
    always_comb begin
        rd_nxt = 8'h00;
        if (bus_req.rd) begin
            case (bus_req.addr)
                ntd_pkg::OFS_DIV_HIGH: rd_nxt = {lock_dis_r, 4'h0, div_r[10:8]};
                ntd_pkg::OFS_DIV_LOW:  rd_nxt = div_r[7:0];
                ntd_pkg::OFS_CONFIG:   rd_nxt = {7'h00, ref_sel_r};
                default:               rd_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rd_r <= 8'h00;
        end else begin
            rd_r <= rd_nxt;
        end
    end

    assign rd_data            = rd_r;
    assign timebase_tick      = tick_r;
    assign divider_ref_select = ref_sel_r;

    // Assertions.
    zero_div_quiet_a: assert property (@(posedge ref_clk) disable iff (srst)
        $past(div_r) == '0 && !$past(srst) |-> !tick_r)
        else $error("tick with zero divisor");

    // A count above the divisor is legal after the divisor was lowered.
    tick_on_ref_a: assert property (@(posedge ref_clk) disable iff (srst)
        tick_r |-> $past(ref_edge) && $past(cnt_r) >= $past(div_r) - 11'h001)
        else $error("tick not at divisor count");

    ref_select_a: assert property (@(posedge ref_clk) disable iff (srst)
        $changed(cnt_r) && !$past(srst) && $past(div_r) != '0 |->
        $past(ref_sel_r ? ref_pulse.bus_ref : ref_pulse.osc_ref))
        else $error("counter moved without selected reference");

    locked_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
        (wr_hi || wr_lo) && !lock_dis_r |=> $stable(div_r) && !lock_dis_r)
        else $error("locked divisor changed");

    latch_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
        (wr_hi || wr_lo) && memory_latch_bit |=> $stable(div_r))
        else $error("divisor changed while latched");

    map_off_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
        bus_req.wr && !map_active |=> $stable(div_r) && $stable(lock_dis_r))
        else $error("write took effect with map inactive");

    shadow_load_a: assert property (@(posedge ref_clk)
        srst |=> div_r == $past({divisor_high_shadow[2:0], divisor_low_shadow}) &&
        lock_dis_r == $past(divisor_high_shadow[7]))
        else $error("reset did not load shadow bytes");

    reset_clear_a: assert property (@(posedge ref_clk)
        srst |=> cnt_r == '0 && !tick_r && rd_data == 8'h00)
        else $error("reset left counter or outputs set");

    low_write_a: assert property (@(posedge ref_clk) disable iff (srst)
        wr_lo && div_wr_ok |=> div_r[7:0] == $past(bus_req.wdata))
        else $error("low divisor write lost");

    high_write_a: assert property (@(posedge ref_clk) disable iff (srst)
        wr_hi && div_wr_ok |=>
        div_r[10:8] == $past(bus_req.wdata[ntd_pkg::DIV_HI_MSB:0]))
        else $error("high divisor write lost");

    // Once locked, nothing short of a reset may unlock the divisor again.
    lock_sticky_a: assert property (@(posedge ref_clk) disable iff (srst)
        !lock_dis_r |=> !lock_dis_r)
        else $error("lock released without reset");

    config_write_a: assert property (@(posedge ref_clk) disable iff (srst)
        bus_req.wr && bus_req.addr == ntd_pkg::OFS_CONFIG |=>
        ref_sel_r == $past(bus_req.wdata[ntd_pkg::REF_SEL_BIT]))
        else $error("reference select write lost");

    readback_a: assert property (@(posedge ref_clk) disable iff (srst)
        bus_req.rd && bus_req.addr == ntd_pkg::OFS_DIV_LOW && !bus_req.wr
        |=> rd_data == $past(div_r[7:0]))
        else $error("low divisor readback wrong");

    high_readback_a: assert property (@(posedge ref_clk) disable iff (srst)
        bus_req.rd && bus_req.addr == ntd_pkg::OFS_DIV_HIGH && !bus_req.wr
        |=> rd_data == $past({lock_dis_r, 4'h0, div_r[10:8]}))
        else $error("high divisor readback wrong");

    rd_idle_a: assert property (@(posedge ref_clk) disable iff (srst)
        !bus_req.rd |=> rd_data == 8'h00)
        else $error("read data outside read cycle");

    zero_cnt_a: assert property (@(posedge ref_clk) disable iff (srst)
        div_r == '0 |=> cnt_r == '0)
        else $error("counter ran with zero divisor");

    tick_pulse_a: assert property (@(posedge ref_clk) disable iff (srst)
        tick_r && div_r > 11'h001 |=> !tick_r)
        else $error("tick longer than one cycle");

    tick_seen_c:   cover property (@(posedge ref_clk) disable iff (srst) tick_r);
    lock_clear_c:  cover property (@(posedge ref_clk) disable iff (srst) $fell(lock_dis_r));
    bus_sel_c:     cover property (@(posedge ref_clk) disable iff (srst) ref_sel_r && tick_r);
    div_write_c:   cover property (@(posedge ref_clk) disable iff (srst) wr_hi && div_wr_ok);
    latch_block_c: cover property (@(posedge ref_clk) disable iff (srst)
        wr_lo && memory_latch_bit);
endmodule
`default_nettype wire

// file: tb/ntd_ref_model.sv
// Reference strobe source and tick counter standing in for the program/erase timer.
`default_nettype none
module ntd_ref_model (
    input  wire logic         ref_clk,
    input  wire logic         srst,
    input  wire logic         timebase_tick,
    output ntd_pkg::ntd_ref_t ref_pulse,
    output logic [15:0]       tick_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] ph_r;
    always_ff @(posedge ref_clk) begin
        ph_r <= (srst || ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
    end
    // Oscillator strobe every second cycle, bus strobe every third cycle.
    assign ref_pulse = '{osc_ref: ~ph_r[0], bus_ref: (ph_r == 3'h0) || (ph_r == 3'h3)};
    always_ff @(posedge ref_clk) begin
        tick_cnt <= srst ? 16'h0000 : tick_cnt + {15'h0000, timebase_tick};
    end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking testbench of the timebase divider.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic              ref_clk = 1'b0;
    logic              srst    = 1'b1;
    ntd_pkg::ntd_req_t bus_req = '0;
    logic [7:0]        rd_data;
    ntd_pkg::ntd_ref_t ref_pulse;
    logic              latch   = 1'b0;
    logic              map_on  = 1'b1;
    logic              tick;
    logic              sel;
    logic [15:0]       tick_cnt;
    logic [15:0]       snap;
    int                err_total = 0;
    int                n_tests   = 0;
    always #25 ref_clk = ~ref_clk;
    ntd_divider u_ntd_divider (.ref_clk(ref_clk), .srst(srst), .bus_req(bus_req),
        .rd_data(rd_data), .ref_pulse(ref_pulse), .divisor_high_shadow(8'h85),
        .divisor_low_shadow(8'h3C), .memory_latch_bit(latch), .map_active(map_on),
        .timebase_tick(tick), .divider_ref_select(sel));
    ntd_ref_model u_ntd_ref_model (.ref_clk(ref_clk), .srst(srst), .timebase_tick(tick),
        .ref_pulse(ref_pulse), .tick_cnt(tick_cnt));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1 check("rd_data", {8'h00, exp}, {8'h00, rd_data});
        @(posedge ref_clk);
    endtask
    // Measures the cycles between two ticks, each wait bounded.
    task automatic period(input int exp);
        int n;
        for (n = 0; n < 400 && tick !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
        if (tick !== 1'b1) begin
            err_total++;
            $display("unexpected tick start: expected 1 seen %0b", tick);
        end
        n = 0;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (tick !== 1'b1 && n < 400);
        check("tick period", exp[15:0], n[15:0]);
        @(posedge ref_clk);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        rd(8'h00, 8'h85);
        rd(8'h01, 8'h3C);
        rd(8'h05, 8'h00);
        wr(8'h00, 8'h80);
        wr(8'h01, 8'h02);
        rd(8'h01, 8'h02);
        period(4);
        wr(8'h02, 8'h01);
        check("ref select", 16'h0001, {15'h0000, sel});
        wr(8'h01, 8'h02);
        period(6);
        latch <= 1'b1;
        wr(8'h01, 8'h07);
        rd(8'h01, 8'h02);
        latch <= 1'b0;
        map_on <= 1'b0;
        wr(8'h01, 8'h07);
        rd(8'h01, 8'h02);
        map_on <= 1'b1;
        wr(8'h00, 8'h87);
        rd(8'h00, 8'h87);
        wr(8'h00, 8'h80);
        wr(8'h01, 8'h00);
        rd(8'h01, 8'h00);
        snap = tick_cnt;
        repeat (60) @(posedge ref_clk);
        check("tick count", snap, tick_cnt);
        wr(8'h00, 8'h00);
        wr(8'h01, 8'h05);
        wr(8'h00, 8'h80);
        rd(8'h00, 8'h00);
        rd(8'h01, 8'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
